// ### trig_rec_pkg.sv
// Summary of operation
// [RL1] Samples go into a 1024-word capture memory, window placed by the delay value.
// [RL2] Clock delay of 500 splits memory roughly half before, half after trigger.
// [RL3] Clock delay of 800 keeps about one fifth before, four fifths after.
// [RL4] Event mode waits for the programmed event count plus one extra event.
// [RL5] Event delay: 501 words before, 523 words from the trigger word on.
// [RL6] Arming starts automatic; first manual arm switches to manual for good.
// [RL7] Armed: record and flag awaiting trigger; flag ready once record completes.
// [RL8] Sample rate defaults to every clock; period selectable slower, e.g. 50 ns.
// [RL9] Enable qualifier in automatic setting does not gate recording.
// [RL10] Reset defaults: full rate, half pretrigger, channel zero, automatic arming.
// [RL11] Delay counter ends record N samples after trigger, or a tail after event N+1.
// [RL12] Processor starts record cycles, except where automatic arming starts one from idle, and may abort one early.
// [RL13] Memory written circularly until delay expires, then holds final 1024 samples.
`default_nettype none

package trig_rec_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DW        = 32;
	localparam int AW        = 8;
	localparam int PW        = 16;
	localparam int MA        = 10;
	localparam int MEM_DEPTH = 1024;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [AW-1:0] OFS_CTRL      = 8'h00;
	localparam logic [AW-1:0] OFS_DELAY     = 8'h04;
	localparam logic [AW-1:0] OFS_PERIOD    = 8'h08;
	localparam logic [AW-1:0] OFS_TRIG_VAL  = 8'h0C;
	localparam logic [AW-1:0] OFS_TRIG_MASK = 8'h10;
	localparam logic [AW-1:0] OFS_EN_VAL    = 8'h14;
	localparam logic [AW-1:0] OFS_EN_MASK   = 8'h18;
	localparam logic [AW-1:0] OFS_STATUS    = 8'h1C;
	localparam logic [AW-1:0] OFS_IRQ_STAT  = 8'h20;
	localparam logic [AW-1:0] OFS_IRQ_CLR   = 8'h24;
	localparam logic [AW-1:0] OFS_IRQ_EN    = 8'h28;
	localparam logic [AW-1:0] OFS_RD_INDEX  = 8'h2C;
	localparam logic [AW-1:0] OFS_RD_DATA   = 8'h30;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_ARM      = 0;
	localparam int CTRL_ABORT    = 1;
	localparam int CTRL_EVT_MODE = 2;
	localparam int CTRL_EN_AUTO  = 3;
	localparam int ST_RECORDING  = 0;
	localparam int ST_AWAIT      = 1;
	localparam int ST_READY      = 2;
	localparam int ST_MANUAL     = 3;
	localparam int ST_WPTR_LSB   = 16;
	localparam int IRQ_TRIG      = 0;
	localparam int IRQ_DONE      = 1;
	localparam int IRQ_ABORT     = 2;
	localparam int IRQ_W         = 3;

	// ----------------------------------------
	// Reset values and timing
	// ----------------------------------------
	localparam int            CLK_PERIOD_NS  = 10;
	localparam int            SAMPLE_MIN_NS  = 10;
	localparam logic [PW-1:0] PERIOD_RST     = PW'(SAMPLE_MIN_NS / CLK_PERIOD_NS);
	localparam logic [PW-1:0] DELAY_RST      = 16'h01F4;
	localparam logic [PW-1:0] TRIG_VAL_RST   = 16'h0001;
	localparam logic [PW-1:0] TRIG_MASK_RST  = 16'h0001;
	localparam logic [PW-1:0] EN_VAL_RST     = 16'h0001;
	localparam logic [PW-1:0] EN_MASK_RST    = 16'h0001;
	localparam logic          EVT_MODE_RST   = 1'b0;
	localparam logic          EN_AUTO_RST    = 1'b1;
	localparam logic [PW-1:0] EVT_POST_WORDS = 16'h020B;
	localparam logic [PW-1:0] EVT_TAIL       = EVT_POST_WORDS - 16'h0001;

	typedef enum logic [1:0] {REC_IDLE, REC_WAIT, REC_POST, REC_DONE} rec_state_t;

endpackage

`default_nettype wire

// ### trig_rec_mem_if.sv
`default_nettype none

interface trig_rec_mem_if;
	import trig_rec_pkg::*;

	logic          we;
	logic [MA-1:0] waddr;
	logic [PW-1:0] wdata;
	logic [MA-1:0] raddr;
	logic [PW-1:0] rdata;

	modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// ### trig_rec_mem.sv
`default_nettype none

module trig_rec_mem
	import trig_rec_pkg::*;
(
	// Clock
	input  wire logic clk_sys,
	// Memory port
	trig_rec_mem_if.mem port
);

	logic [PW-1:0] cells [MEM_DEPTH];

	// No reset on the array: it is plain storage
	always_ff @(posedge clk_sys) begin
		if (port.we) begin
			cells[port.waddr] <= port.wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		port.rdata <= cells[port.raddr];
	end

endmodule

`default_nettype wire

// ### trig_rec_ctl.sv
`default_nettype none

module trig_rec_ctl
	import trig_rec_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// Register port
	input  wire logic [AW-1:0] reg_addr,
	input  wire logic [DW-1:0] reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output var  logic [DW-1:0] reg_rdata,
	// Probed target
	input  wire logic [PW-1:0] probe_data,
	// Status
	output var  logic          awaiting_trigger_status,
	output var  logic          record_ready,
	output var  logic          trig_out,
	output var  logic          irq
);

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic reg_hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
		return a == ofs;
	endfunction

	function automatic logic word_match(input logic [PW-1:0] w,
		input logic [PW-1:0] val, input logic [PW-1:0] mask);
		return ((w ^ val) & mask) == '0;
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	trig_rec_mem_if mem_bus ();

	rec_state_t    state_q;
	logic          evt_mode_q;
	logic          en_auto_q;
	logic          manual_q;
	logic [PW-1:0] delay_q;
	logic [PW-1:0] period_q;
	logic [PW-1:0] trig_val_q;
	logic [PW-1:0] trig_mask_q;
	logic [PW-1:0] en_val_q;
	logic [PW-1:0] en_mask_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_en_q;
	logic [IRQ_W-1:0] irq_ev;
	logic [MA-1:0] rd_index_q;
	logic [PW-1:0] tick_cnt_q;
	logic [MA-1:0] wptr_q;
	logic [PW-1:0] remain_q;
	logic [PW-1:0] evt_cnt_q;
	logic          trig_prev_q;
	logic          tick;
	logic          recording;
	logic          sample;
	logic          trig_now;
	logic          trig_edge;
	logic          last_event;
	logic          wr_ctrl;
	logic          arm_req;
	logic          abort_req;
	logic          start;
	logic          done_ev;
	logic [PW-1:0] post_target;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign wr_ctrl   = reg_wr && reg_hit(reg_addr, OFS_CTRL);
	assign arm_req   = wr_ctrl && reg_wdata[CTRL_ARM];
	assign abort_req = wr_ctrl && reg_wdata[CTRL_ABORT] && !reg_wdata[CTRL_ARM];

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			evt_mode_q <= EVT_MODE_RST;  // [RL10]
			en_auto_q  <= EN_AUTO_RST;  // [RL10]
		end else if (wr_ctrl) begin
			evt_mode_q <= reg_wdata[CTRL_EVT_MODE];
			en_auto_q  <= reg_wdata[CTRL_EN_AUTO];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			delay_q  <= DELAY_RST;  // [RL2] [RL10]
			period_q <= PERIOD_RST;  // [RL8] [RL10]
		end else if (reg_wr) begin
			if (reg_hit(reg_addr, OFS_DELAY)) begin
				delay_q <= reg_wdata[PW-1:0];  // [RL1] [RL3]
			end
			if (reg_hit(reg_addr, OFS_PERIOD)) begin
				period_q <= reg_wdata[PW-1:0];  // [RL8]
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trig_val_q  <= TRIG_VAL_RST;  // [RL10]
			trig_mask_q <= TRIG_MASK_RST;
			en_val_q    <= EN_VAL_RST;
			en_mask_q   <= EN_MASK_RST;
		end else if (reg_wr) begin
			if (reg_hit(reg_addr, OFS_TRIG_VAL)) begin
				trig_val_q <= reg_wdata[PW-1:0];
			end
			if (reg_hit(reg_addr, OFS_TRIG_MASK)) begin
				trig_mask_q <= reg_wdata[PW-1:0];
			end
			if (reg_hit(reg_addr, OFS_EN_VAL)) begin
				en_val_q <= reg_wdata[PW-1:0];
			end
			if (reg_hit(reg_addr, OFS_EN_MASK)) begin
				en_mask_q <= reg_wdata[PW-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_index_q <= '0;
		end else if (reg_wr && reg_hit(reg_addr, OFS_RD_INDEX)) begin
			rd_index_q <= reg_wdata[MA-1:0];
		end
	end

	// ----------------------------------------
	// Arm mode
	// ----------------------------------------
	// One-way switch: nothing but reset returns to automatic arming
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			manual_q <= 1'b0;  // [RL6] [RL10]
		end else if (arm_req) begin
			manual_q <= 1'b1;  // [RL6]
		end
	end

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	// A period of zero behaves as one, so the time base never stalls
	assign tick = (tick_cnt_q + 16'h0001 >= period_q);  // [RL8]

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_q <= '0;
		end else if (tick || start) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;  // [RL8]
		end
	end

	// ----------------------------------------
	// Sampling and trigger detection
	// ----------------------------------------
	assign recording = (state_q == REC_WAIT) || (state_q == REC_POST);
	assign sample    = recording && tick &&
		(en_auto_q || word_match(probe_data, en_val_q, en_mask_q));  // [RL9]
	assign trig_now  = word_match(probe_data, trig_val_q, trig_mask_q);
	// Trigger on the transition into the word, not while it stays true
	assign trig_edge = sample && trig_now && !trig_prev_q;
	assign last_event = (evt_cnt_q == delay_q);  // [RL4]
	assign post_target = evt_mode_q ? EVT_TAIL : delay_q;  // [RL5] [RL11]
	assign start = arm_req || (state_q == REC_IDLE && !manual_q);  // [RL6] [RL12]

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trig_prev_q <= 1'b0;
		end else if (start) begin
			trig_prev_q <= 1'b0;
		end else if (sample) begin
			trig_prev_q <= trig_now;
		end
	end

	// ----------------------------------------
	// Record sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= REC_IDLE;
			remain_q  <= '0;
			evt_cnt_q <= '0;
		end else if (abort_req && recording) begin
			state_q <= REC_IDLE;  // [RL12]
		end else if (start) begin
			state_q   <= REC_WAIT;  // [RL7] [RL12]
			evt_cnt_q <= '0;
		end else begin
			unique case (state_q)
				REC_IDLE: begin
					state_q <= REC_IDLE;
				end
				REC_WAIT: begin
					if (trig_edge) begin
						if (evt_mode_q && !last_event) begin
							evt_cnt_q <= evt_cnt_q + 16'h0001;  // [RL4]
						end else if (post_target == '0) begin
							state_q <= REC_DONE;  // [RL11]
						end else begin
							state_q  <= REC_POST;  // [RL7]
							remain_q <= post_target;  // [RL11]
						end
					end
				end
				REC_POST: begin
					if (sample) begin
						remain_q <= remain_q - 16'h0001;  // [RL11]
						if (remain_q == 16'h0001) begin
							state_q <= REC_DONE;  // [RL13]
						end
					end
				end
				REC_DONE: begin
					state_q <= REC_DONE;
				end
			endcase
		end
	end

	assign done_ev = (state_q == REC_POST) && sample && (remain_q == 16'h0001) ||
		(state_q == REC_WAIT) && trig_edge && !(evt_mode_q && !last_event) &&
		(post_target == '0);

	// ----------------------------------------
	// Capture memory
	// ----------------------------------------
	// Pointer rests on the oldest word once the record stops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wptr_q <= '0;
		end else if (sample && !(abort_req && recording)) begin
			wptr_q <= wptr_q + 10'h001;  // [RL13]
		end
	end

	assign mem_bus.we    = sample && !(abort_req && recording);  // [RL1] [RL13]
	assign mem_bus.waddr = wptr_q;
	assign mem_bus.wdata = probe_data;
	// Index is relative to the oldest word, so index 0 is the first kept sample
	assign mem_bus.raddr = wptr_q + ((reg_wr && reg_hit(reg_addr, OFS_RD_INDEX)) ?
		reg_wdata[MA-1:0] : rd_index_q);  // [RL2] [RL3] [RL5]

	trig_rec_mem u_mem (
		.clk_sys (clk_sys),
		.port    (mem_bus.mem)
	);

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always_comb begin
		irq_ev            = '0;
		irq_ev[IRQ_TRIG]  = trig_edge && (state_q == REC_WAIT);
		irq_ev[IRQ_DONE]  = done_ev;
		irq_ev[IRQ_ABORT] = abort_req && recording;
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_q <= '0;
		end else if (reg_wr && reg_hit(reg_addr, OFS_IRQ_CLR)) begin
			irq_stat_q <= (irq_stat_q & ~reg_wdata[IRQ_W-1:0]) | irq_ev;
		end else begin
			irq_stat_q <= irq_stat_q | irq_ev;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_q <= '0;
		end else if (reg_wr && reg_hit(reg_addr, OFS_IRQ_EN)) begin
			irq_en_q <= reg_wdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_en_q);
		end
	end

	// ----------------------------------------
	// Status outputs
	// ----------------------------------------
	// Registered from state, so they trail the sequencer by one cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			awaiting_trigger_status <= 1'b0;
			record_ready            <= 1'b0;
			trig_out                <= 1'b0;
		end else begin
			awaiting_trigger_status <= (state_q == REC_WAIT);  // [RL7]
			record_ready            <= (state_q == REC_DONE);  // [RL7]
			trig_out                <= recording && trig_now;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (!reg_rd) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
			unique case (reg_addr)
				OFS_CTRL: begin
					reg_rdata[CTRL_EVT_MODE] <= evt_mode_q;
					reg_rdata[CTRL_EN_AUTO]  <= en_auto_q;
				end
				OFS_DELAY: begin
					reg_rdata[PW-1:0] <= delay_q;
				end
				OFS_PERIOD: begin
					reg_rdata[PW-1:0] <= period_q;
				end
				OFS_TRIG_VAL: begin
					reg_rdata[PW-1:0] <= trig_val_q;
				end
				OFS_TRIG_MASK: begin
					reg_rdata[PW-1:0] <= trig_mask_q;
				end
				OFS_EN_VAL: begin
					reg_rdata[PW-1:0] <= en_val_q;
				end
				OFS_EN_MASK: begin
					reg_rdata[PW-1:0] <= en_mask_q;
				end
				OFS_STATUS: begin
					reg_rdata[ST_RECORDING] <= recording;
					reg_rdata[ST_AWAIT]     <= (state_q == REC_WAIT);  // [RL7]
					reg_rdata[ST_READY]     <= (state_q == REC_DONE);  // [RL7]
					reg_rdata[ST_MANUAL]    <= manual_q;  // [RL6]
					reg_rdata[ST_WPTR_LSB +: MA] <= wptr_q;
				end
				OFS_IRQ_STAT: begin
					reg_rdata[IRQ_W-1:0] <= irq_stat_q;
				end
				OFS_IRQ_EN: begin
					reg_rdata[IRQ_W-1:0] <= irq_en_q;
				end
				OFS_RD_INDEX: begin
					reg_rdata[MA-1:0] <= rd_index_q;
				end
				OFS_RD_DATA: begin
					reg_rdata[PW-1:0] <= mem_bus.rdata;  // [RL1]
				end
				default: begin
					reg_rdata <= '0;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ### trig_rec_ctl_asserts.sv
`default_nettype none

module trig_rec_ctl_asserts
	import trig_rec_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// Register port and status
	input  wire logic [AW-1:0] reg_addr,
	input  wire logic [DW-1:0] reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	input  wire logic [DW-1:0] reg_rdata,
	input  wire logic [PW-1:0] probe_data,
	input  wire logic          awaiting_trigger_status,
	input  wire logic          record_ready,
	input  wire logic          trig_out,
	input  wire logic          irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// ----------------
	// Checks
	// ----------------
	a_status_excl: assert property (!(awaiting_trigger_status && record_ready))
		else $error("awaiting and ready both high");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data outside read slot");
	a_unmapped_zero: assert property (
		reg_rd && reg_addr > OFS_RD_DATA |=> reg_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_arm_waits: assert property (
		reg_wr && reg_addr == OFS_CTRL && reg_wdata[1:0] == 2'b01 |=> ##1 awaiting_trigger_status)
		else $error("arm did not enter wait");
	a_done_holds: assert property (
		record_ready && !reg_wr && !$past(reg_wr) |=> record_ready)
		else $error("ready dropped without arm");
	a_trig_cause: assert property (trig_out |-> $past(probe_data[0]))
		else $error("trigger output without trigger word");
	a_post_bound: assert property (
		$fell(awaiting_trigger_status) && $past(trig_out) |-> ##[1:1000] record_ready)
		else $error("record did not end in time");
	a_irq_masked: assert property (
		reg_wr && reg_addr == OFS_IRQ_EN && reg_wdata[2:0] == 3'h0 |=> ##1 !irq)
		else $error("interrupt high while masked");
	c_done: cover property ($rose(record_ready));
	c_trig: cover property (trig_out && awaiting_trigger_status);
	c_irq: cover property ($rose(irq));
endmodule

bind trig_rec_ctl trig_rec_ctl_asserts i_trig_rec_ctl_asserts (
	.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .probe_data(probe_data),
	.awaiting_trigger_status(awaiting_trigger_status), .record_ready(record_ready),
	.trig_out(trig_out), .irq(irq)
);

`default_nettype wire

// ### probe_src.sv
`default_nettype none

module probe_src
	import trig_rec_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	// Channel zero request and probe lines
	input  wire logic          level,
	output var  logic [PW-1:0] probe_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// Upper lines count clocks, so each stored word tells when it was taken
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			probe_data <= 16'h0000;
		end else begin
			probe_data <= {probe_data[15:1] + 15'h0001, level};
		end
	end
endmodule

`default_nettype wire

// ### tb_top.sv
`default_nettype none

module tb_top
	import trig_rec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic          clk_sys;
	logic          rst_n;
	logic [AW-1:0] reg_addr;
	logic [DW-1:0] reg_wdata;
	logic          reg_wr;
	logic          reg_rd;
	logic [DW-1:0] reg_rdata;
	logic [PW-1:0] probe_data;
	logic          awaiting_trigger_status;
	logic          record_ready;
	logic          trig_out;
	logic          irq;
	logic          level;
	int            err_count;
	int            check_count;
	int            cycles;

	trig_rec_ctl i_trig_rec_ctl (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.probe_data(probe_data), .awaiting_trigger_status(awaiting_trigger_status),
		.record_ready(record_ready), .trig_out(trig_out), .irq(irq));
	probe_src i_probe_src (.clk_sys(clk_sys), .rst_n(rst_n), .level(level),
		.probe_data(probe_data));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ----------------
	// Helpers
	// ----------------
	task automatic check(input string name, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic mem(input int idx, output logic [PW-1:0] w);
		logic [DW-1:0] d;
		wr(OFS_RD_INDEX, DW'(idx));
		rd(OFS_RD_DATA, d);
		w = d[PW-1:0];
	endtask

	task automatic mbit(input int idx, input logic e);
		logic [PW-1:0] w;
		mem(idx, w);
		check("stored channel zero", DW'(w[0]), DW'(e));
	endtask

	// Stamp difference of two stored words, in clocks
	task automatic gap(input int hi, input int lo, input logic [14:0] e);
		logic [PW-1:0] a;
		logic [PW-1:0] b;
		mem(hi, a);
		mem(lo, b);
		check("sample spacing", DW'(15'(a[15:1] - b[15:1])), DW'(e));
	endtask

	// Long enough to be seen at the slowest period used here
	task automatic pulse;
		@(posedge clk_sys);
		level <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 check("trigger output", DW'(trig_out), DW'(1'b1));
		repeat (9) @(posedge clk_sys);
		level <= 1'b0;
		repeat (12) @(posedge clk_sys);
	endtask

	task automatic wait_ready;
		int n;
		n = 0;
		while (record_ready !== 1'b1 && n < 3000) begin
			@(posedge clk_sys);
			#1 n++;
		end
		check("record ready", DW'(record_ready), DW'(1'b1));
	endtask

	// ----------------
	// Scenarios
	// ----------------
	task automatic t_defaults;
		logic [DW-1:0] d;
		rd(OFS_DELAY, d);
		check("delay at reset", d, 32'h0000_01F4);
		rd(OFS_PERIOD, d);
		check("period at reset", d, 32'h0000_0001);
		rd(OFS_TRIG_MASK, d);
		check("trigger mask at reset", d, 32'h0000_0001);
		rd(OFS_STATUS, d);
		check("status at reset", d & 32'h0000_000F, 32'h0000_0003);
		rd(8'h40, d);
		check("unmapped read", d, 32'h0000_0000);
	endtask

	task automatic t_half;
		logic [DW-1:0] d;
		wr(OFS_IRQ_EN, 32'h0000_0002);
		repeat (1100) @(posedge clk_sys);
		pulse();
		wait_ready();
		check("awaiting after end", DW'(awaiting_trigger_status), DW'(1'b0));
		mbit(1023 - 500, 1'b1);
		mbit(1022 - 500, 1'b0);
		gap(1023, 0, 15'h03FF);
		check("irq raised", DW'(irq), DW'(1'b1));
		rd(OFS_IRQ_STAT, d);
		check("done event", d & 32'h0000_0002, 32'h0000_0002);
		wr(OFS_IRQ_CLR, 32'h0000_0002);
		repeat (2) @(posedge clk_sys);
		#1 check("irq cleared", DW'(irq), DW'(1'b0));
		wr(OFS_IRQ_EN, 32'h0000_0000);
	endtask

	task automatic t_800;
		logic [DW-1:0] d;
		wr(OFS_DELAY, 32'h0000_0320);
		wr(OFS_CTRL, 32'h0000_0009);
		rd(OFS_STATUS, d);
		check("manual arming", d & 32'h0000_0008, 32'h0000_0008);
		repeat (1100) @(posedge clk_sys);
		pulse();
		wait_ready();
		mbit(1023 - 800, 1'b1);
		mbit(1022 - 800, 1'b0);
	endtask

	task automatic t_event;
		wr(OFS_DELAY, 32'h0000_0003);
		wr(OFS_CTRL, 32'h0000_000D);
		repeat (1100) @(posedge clk_sys);
		repeat (3) pulse();
		#1 check("still awaiting", DW'(awaiting_trigger_status), DW'(1'b1));
		pulse();
		wait_ready();
		mbit(1023 - 522, 1'b1);
		mbit(1022 - 522, 1'b0);
	endtask

	task automatic t_period;
		wr(OFS_PERIOD, 32'h0000_0005);
		wr(OFS_DELAY, 32'h0000_000A);
		wr(OFS_CTRL, 32'h0000_0009);
		repeat (100) @(posedge clk_sys);
		pulse();
		wait_ready();
		gap(1023, 1022, 15'h0005);
		mbit(1023 - 10, 1'b1);
	endtask

	task automatic t_abort;
		logic [DW-1:0] d;
		wr(OFS_CTRL, 32'h0000_0009);
		repeat (4) @(posedge clk_sys);
		#1 check("armed", DW'(awaiting_trigger_status), DW'(1'b1));
		wr(OFS_CTRL, 32'h0000_000A);
		repeat (2) @(posedge clk_sys);
		#1 check("aborted", DW'(awaiting_trigger_status), DW'(1'b0));
		rd(OFS_IRQ_STAT, d);
		check("abort event", d & 32'h0000_0004, 32'h0000_0004);
	endtask

	task automatic conclude;
		if (err_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			conclude();
		end
	end

	initial begin
		rst_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		level = 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_defaults();
		t_half();
		t_800();
		t_event();
		t_period();
		t_abort();
		conclude();
	end
endmodule

`default_nettype wire
